// ---- hdl/imcc_defs.svh ----
`ifndef IMCC_DEFS_SVH
`define IMCC_DEFS_SVH
// Function
// - Mask bit 0 gates sweep flag
// - Continuous sweep pulses interrupt 100ns each end
// - Mask bit 1 gates ADC ready
// - Mask bit 2 gates ADC missed
// - Mask bit 3 gates input events, overrides modes
// - Bit 4 cleared only with bit 3 clear
// - Mask bit 5 gates driver overcurrent
// - Bits 14:6 gate temperature bits individually
// - Mask bit 15 gates supply monitor
// - Edge mode: none, rise, fall, both
// - Edge fields split over two registers
// - Conversion mode 00 keeps ADC idle
// - Mode 01: start triggers one sweep
// - Mode 10: start converts current port, advance
// - Mode 11: sweep continuously, ignore start
// - Output mode 00 refreshes ports sequentially
// - Output mode 01 updates new port next
// - Modes 10/11 use shared presets a/b
// - Rate field selects 200/250/333/400 ksps
// - Event status records regardless; read-sequence clear

// Register byte offsets
`define IMCC_OFS_MASK 5'h00
`define IMCC_OFS_EDGE_LO 5'h04
`define IMCC_OFS_EDGE_HI 5'h08
`define IMCC_OFS_CTRL 5'h0C
`define IMCC_OFS_PEND 5'h10
`define IMCC_OFS_STAT_LO 5'h14
`define IMCC_OFS_STAT_HI 5'h18

// Reset values
`define IMCC_RST_MASK 16'hFFFF
`define IMCC_RST_EDGE 16'h0000
`define IMCC_RST_CTRL 16'h0000

// Mask and pending bit positions
`define IMCC_BIT_SWEEP 0
`define IMCC_BIT_ADC_RDY 1
`define IMCC_BIT_ADC_MISS 2
`define IMCC_BIT_EV_RDY 3
`define IMCC_BIT_EV_MISS 4
`define IMCC_BIT_OVC 5
`define IMCC_BIT_TEMP_LO 6
`define IMCC_BIT_SUPPLY 15

// Control field positions
`define IMCC_CONV_LSB 0
`define IMCC_UPD_LSB 2
`define IMCC_RATE_LSB 4

// Timing
`define IMCC_CLK_KHZ 250000
`define IMCC_PULSE_NS 100
`define IMCC_PULSE_CYC ((`IMCC_PULSE_NS * `IMCC_CLK_KHZ) / 1000000)
`define IMCC_RATE0_KSPS 200
`define IMCC_RATE1_KSPS 250
`define IMCC_RATE2_KSPS 333
`define IMCC_RATE3_KSPS 400
`define IMCC_CONV_CYC(k) (`IMCC_CLK_KHZ / (k))
`endif

// ---- hdl/imcc_pkg.sv ----
package imcc_pkg;
    typedef enum logic [1:0] {IMCC_CONV_IDLE, IMCC_CONV_SWEEP, IMCC_CONV_SINGLE,
        IMCC_CONV_CONT} imcc_conv_mode_t;
    typedef enum logic [1:0] {IMCC_UPD_SEQ, IMCC_UPD_IMM, IMCC_UPD_PRESET_A,
        IMCC_UPD_PRESET_B} imcc_upd_mode_t;
    typedef struct packed {
        logic adc_ready_irq;
        logic adc_missed_irq;
        logic driver_overcurrent_irq;
        logic [2:0] internal_temp_irq;
        logic [2:0] remote_temp_a_irq;
        logic [2:0] remote_temp_b_irq;
        logic supply_monitor_irq;
    } imcc_events_t;
    typedef struct packed {
        logic strobe;
        logic [3:0] port;
        logic [1:0] source;
    } imcc_port_cmd_t;
endpackage

// ---- hdl/imcc_top.sv ----
// Design decisions made here: register access over Avalon-MM and the register addresses.
`include "imcc_defs.svh"

module imcc_top import imcc_pkg::*; #(
    parameter int PORTS = 12,
    parameter int DAC_STEP_CYC = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port configuration and pins
    input wire logic [PORTS-1:0] adc_port_map,
    input wire logic [PORTS-1:0] dac_port_map,
    input wire logic [PORTS-1:0] gpi_pins,
    input wire logic conversion_start_in,
    // Event pulses from the analog side
    input wire imcc_events_t events,
    input wire logic dac_new_data,
    input wire logic [3:0] dac_new_port,
    // Converter commands and interrupt output
    output imcc_port_cmd_t adc_cmd,
    output imcc_port_cmd_t dac_cmd,
    output logic [1:0] conversion_rate_sel,
    output logic int_n
);
    // ========================================
    // Helpers
    function automatic logic [3:0] find_from(input logic [PORTS-1:0] map, input logic [4:0] from);
        logic [3:0] r;
        r = 4'hF;
        for (int i = PORTS - 1; i >= 0; i--) begin
            if (map[i] && 5'(i) >= from) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] edge_field(input logic [15:0] lo, input logic [15:0] hi,
            input int p);
        logic [1:0] r;
        r = 2'h0;
        if (p < 6) begin
            r = lo[4 + 2 * p +: 2];
        end else if (p < 11) begin
            r = hi[6 + 2 * (p - 6) +: 2];
        end else begin
            r = hi[1:0];
        end
        return r;
    endfunction

    // ========================================
    // Registers and synchronisers
    logic [15:0] interrupt_mask, input_edge_mode_low, input_edge_mode_high, device_control;
    logic [15:0] pend;
    logic [PORTS-1:0] input_event_status;
    logic [PORTS-1:0] gpi_s1, gpi_s2, gpi_prev;
    logic start_s1, start_s2, start_prev;
    logic clr_armed, seen_lo, seen_hi;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gpi_s1 <= '0;
            gpi_s2 <= '0;
            gpi_prev <= '0;
            start_s1 <= 1'b0;
            start_s2 <= 1'b0;
            start_prev <= 1'b0;
        end else begin
            gpi_s1 <= gpi_pins;
            gpi_s2 <= gpi_s1;
            gpi_prev <= gpi_s2;
            start_s1 <= conversion_start_in;
            start_s2 <= start_s1;
            start_prev <= start_s2;
        end
    end

    wire start_rise = start_s2 && !start_prev;
    // ========================================
    // Bus decode
    wire req = avs_read || avs_write;
    wire do_acc = req && !avs_waitrequest;
    wire do_wr = do_acc && avs_write;
    wire do_rd = do_acc && avs_read;
    wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire wr_mask = do_wr && avs_address == `IMCC_OFS_MASK;
    wire wr_elo = do_wr && avs_address == `IMCC_OFS_EDGE_LO;
    wire wr_ehi = do_wr && avs_address == `IMCC_OFS_EDGE_HI;
    wire wr_ctrl = do_wr && avs_address == `IMCC_OFS_CTRL;
    wire rd_pend = do_rd && avs_address == `IMCC_OFS_PEND;
    wire rd_slo = do_rd && avs_address == `IMCC_OFS_STAT_LO;
    wire rd_shi = do_rd && avs_address == `IMCC_OFS_STAT_HI;
    wire [15:0] wr_bits = avs_writedata[15:0] & wmask;
    wire [15:0] mask_merged = (interrupt_mask & ~wmask) | wr_bits;
    // bit 4 held while bit 3 set
    wire [15:0] next_mask = {mask_merged[15:5],
        mask_merged[4] | mask_merged[3], mask_merged[3:0]};
    wire [15:0] stat_lo_view = {input_event_status[10:6], 3'h0, input_event_status[5:0], 2'h0};
    wire [15:0] stat_hi_view = {15'h0, input_event_status[11]};
    logic [15:0] rd_mux;
    always_comb begin
        unique case (avs_address)
            `IMCC_OFS_MASK: rd_mux = interrupt_mask;
            `IMCC_OFS_EDGE_LO: rd_mux = input_edge_mode_low;
            `IMCC_OFS_EDGE_HI: rd_mux = input_edge_mode_high;
            `IMCC_OFS_CTRL: rd_mux = device_control;
            `IMCC_OFS_PEND: rd_mux = pend;
            `IMCC_OFS_STAT_LO: rd_mux = stat_lo_view;
            `IMCC_OFS_STAT_HI: rd_mux = stat_hi_view;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            interrupt_mask <= `IMCC_RST_MASK;
            input_edge_mode_low <= `IMCC_RST_EDGE;
            input_edge_mode_high <= `IMCC_RST_EDGE;
            device_control <= `IMCC_RST_CTRL;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (req && avs_waitrequest) begin
                avs_readdata <= {16'h0000, rd_mux};
            end
            if (wr_mask) begin
                interrupt_mask <= next_mask;
            end
            if (wr_elo) begin
                input_edge_mode_low <= (input_edge_mode_low & ~wmask) | wr_bits;
            end
            if (wr_ehi) begin
                input_edge_mode_high <= (input_edge_mode_high & ~wmask) | wr_bits;
            end
            if (wr_ctrl) begin
                device_control <= (device_control & ~wmask) | wr_bits;
            end
        end
    end

    imcc_conv_mode_t conv_mode;
    imcc_upd_mode_t upd_mode;
    assign conv_mode = imcc_conv_mode_t'(device_control[`IMCC_CONV_LSB +: 2]);
    assign upd_mode = imcc_upd_mode_t'(device_control[`IMCC_UPD_LSB +: 2]);

    // ========================================
    // Input edge detection
    logic [PORTS-1:0] ev_hit;
    for (genvar p = 0; p < PORTS; p++) begin : g_edge
        wire [1:0] md = edge_field(input_edge_mode_low, input_edge_mode_high, p);
        assign ev_hit[p] = (md[0] && gpi_s2[p] && !gpi_prev[p])
            || (md[1] && !gpi_s2[p] && gpi_prev[p]);
    end
    wire any_ev = |ev_hit;
    wire ev_missed = |(ev_hit & input_event_status);
    wire stat_clear = clr_armed && (seen_lo || rd_slo) && (seen_hi || rd_shi);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            input_event_status <= '0;
            clr_armed <= 1'b0;
            seen_lo <= 1'b0;
            seen_hi <= 1'b0;
        end else begin
            input_event_status <= (stat_clear ? '0 : input_event_status) | ev_hit;
            if (rd_pend) begin
                clr_armed <= 1'b1;
                seen_lo <= 1'b0;
                seen_hi <= 1'b0;
            end else if (stat_clear) begin
                clr_armed <= 1'b0;
                seen_lo <= 1'b0;
                seen_hi <= 1'b0;
            end else begin
                seen_lo <= seen_lo || (clr_armed && rd_slo);
                seen_hi <= seen_hi || (clr_armed && rd_shi);
            end
        end
    end
    // ========================================
    // ADC sequencer
    localparam logic [10:0] CONV_CYC [4] = '{11'(`IMCC_CONV_CYC(`IMCC_RATE0_KSPS)),
        11'(`IMCC_CONV_CYC(`IMCC_RATE1_KSPS)), 11'(`IMCC_CONV_CYC(`IMCC_RATE2_KSPS)),
        11'(`IMCC_CONV_CYC(`IMCC_RATE3_KSPS))};
    logic adc_busy, adc_sweep;
    logic [3:0] adc_port, single_ptr;
    logic [10:0] conv_cnt;
    wire [10:0] conv_len = CONV_CYC[device_control[`IMCC_RATE_LSB +: 2]];
    wire [3:0] first_adc = find_from(adc_port_map, 5'h00);
    wire [3:0] next_adc = find_from(adc_port_map, 5'(adc_port) + 5'h01);
    wire [3:0] single_pick = find_from(adc_port_map, {1'b0, single_ptr});
    wire [3:0] single_go = (single_pick == 4'hF) ? first_adc : single_pick;
    wire conv_done = adc_busy && conv_cnt == 11'h001;
    wire sweep_end = conv_done && adc_sweep && next_adc == 4'hF;
    wire launch_sweep = !adc_busy && first_adc != 4'hF
        && ((conv_mode == IMCC_CONV_SWEEP && start_rise) || conv_mode == IMCC_CONV_CONT);
    wire launch_single = !adc_busy && conv_mode == IMCC_CONV_SINGLE && start_rise
        && first_adc != 4'hF;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            adc_busy <= 1'b0;
            adc_sweep <= 1'b0;
            adc_port <= 4'h0;
            single_ptr <= 4'h0;
            conv_cnt <= 11'h000;
            adc_cmd <= '0;
            conversion_rate_sel <= 2'h0;
        end else begin
            conversion_rate_sel <= device_control[`IMCC_RATE_LSB +: 2];
            adc_cmd.strobe <= 1'b0;
            adc_cmd.source <= 2'h0;
            if (conv_mode == IMCC_CONV_IDLE) begin
                adc_busy <= 1'b0;
                single_ptr <= 4'h0;
            end else if (launch_sweep || launch_single) begin
                adc_busy <= 1'b1;
                adc_sweep <= launch_sweep;
                adc_port <= launch_sweep ? first_adc : single_go;
                conv_cnt <= conv_len;
                adc_cmd.strobe <= 1'b1;
                adc_cmd.port <= launch_sweep ? first_adc : single_go;
                if (launch_single) begin
                    single_ptr <= single_go + 4'h1;
                end
            end else if (conv_done) begin
                if (adc_sweep && next_adc != 4'hF) begin
                    adc_port <= next_adc;
                    conv_cnt <= conv_len;
                    adc_cmd.strobe <= 1'b1;
                    adc_cmd.port <= next_adc;
                end else begin
                    adc_busy <= 1'b0;
                end
            end else if (adc_busy) begin
                conv_cnt <= conv_cnt - 11'h001;
            end
        end
    end
    // ========================================
    // DAC update sequencer
    logic [3:0] dac_ptr, imm_port;
    logic imm_pend;
    logic [$clog2(DAC_STEP_CYC+1)-1:0] dac_cnt;
    wire dac_tick = dac_cnt == '0;
    wire [3:0] dac_look = find_from(dac_port_map, {1'b0, dac_ptr});
    wire [3:0] dac_seq = (dac_look == 4'hF) ? find_from(dac_port_map, 5'h00) : dac_look;
    wire [3:0] dac_pick = (imm_pend && upd_mode == IMCC_UPD_IMM) ? imm_port : dac_seq;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dac_ptr <= 4'h0;
            imm_port <= 4'h0;
            imm_pend <= 1'b0;
            dac_cnt <= '0;
            dac_cmd <= '0;
        end else begin
            dac_cmd.strobe <= 1'b0;
            if (dac_new_data && upd_mode == IMCC_UPD_IMM) begin
                imm_pend <= 1'b1;
                imm_port <= dac_new_port;
            end
            dac_cnt <= dac_tick ? ($bits(dac_cnt))'(DAC_STEP_CYC - 1) : dac_cnt - 1'b1;
            if (dac_tick && dac_seq != 4'hF) begin
                dac_cmd.strobe <= 1'b1;
                dac_cmd.port <= dac_pick;
                dac_cmd.source <= (upd_mode == IMCC_UPD_PRESET_A) ? 2'h1
                    : (upd_mode == IMCC_UPD_PRESET_B) ? 2'h2 : 2'h0;
                dac_ptr <= dac_pick + 4'h1;
                if (!(dac_new_data && upd_mode == IMCC_UPD_IMM)) begin
                    imm_pend <= 1'b0;
                end
            end
        end
    end
    // ========================================
    // Interrupt pending and output
    wire [15:0] pend_set = {events.supply_monitor_irq, events.remote_temp_b_irq,
        events.remote_temp_a_irq, events.internal_temp_irq, events.driver_overcurrent_irq,
        ev_missed, any_ev, events.adc_missed_irq, events.adc_ready_irq, sweep_end};
    wire [15:0] pend_live = pend & ~interrupt_mask;
    logic [4:0] pulse_cnt;
    wire cont_end = sweep_end && conv_mode == IMCC_CONV_CONT;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pend <= 16'h0000;
            pulse_cnt <= 5'h00;
            int_n <= 1'b1;
        end else begin
            pend <= (pend & ~(rd_pend ? avs_readdata[15:0] : 16'h0000)) | pend_set;
            if (cont_end) begin
                pulse_cnt <= 5'(`IMCC_PULSE_CYC);
            end else if (pulse_cnt != 5'h00) begin
                pulse_cnt <= pulse_cnt - 5'h01;
            end
            int_n <= !((|pend_live) || cont_end || pulse_cnt > 5'h01);
        end
    end
    // ========================================
    // Checks
    property p_mask_gate;
        @(posedge sys_clk) disable iff (sys_rst)
        (pulse_cnt == 5'h00 && !cont_end && pend_live == 16'h0000) |=> int_n;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("int low with nothing live");
    property p_live_low;
        @(posedge sys_clk) disable iff (sys_rst)
        (|pend_live) |=> !int_n;
    endproperty
    a_live_low: assert property (p_live_low) else $error("unmasked pending not shown");
    property p_pulse_len;
        @(posedge sys_clk) disable iff (sys_rst)
        cont_end |=> (!int_n) [*8] ##17 (pulse_cnt == 5'h01);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("sweep pulse wrong length");
    property p_miss_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        wr_mask && avs_writedata[3] && avs_byteenable[0] |=> interrupt_mask[4];
    endproperty
    a_miss_hold: assert property (p_miss_hold) else $error("bit 4 cleared under bit 3");
    property p_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        conv_mode == IMCC_CONV_IDLE |=> !adc_cmd.strobe;
    endproperty
    a_idle: assert property (p_idle) else $error("conversion in idle mode");
    property p_status_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        (|ev_hit) |=> (input_event_status & $past(ev_hit)) == $past(ev_hit);
    endproperty
    a_status_keep: assert property (p_status_keep) else $error("event lost");
    property p_ev_pend;
        @(posedge sys_clk) disable iff (sys_rst)
        any_ev |=> pend[`IMCC_BIT_EV_RDY];
    endproperty
    a_ev_pend: assert property (p_ev_pend) else $error("event ready not pending");
    property p_single_one;
        @(posedge sys_clk) disable iff (sys_rst)
        launch_single |=> adc_cmd.strobe ##1 (!adc_cmd.strobe) [*8];
    endproperty
    a_single_one: assert property (p_single_one) else $error("single conversion twice");
    property p_preset;
        @(posedge sys_clk) disable iff (sys_rst)
        dac_tick && dac_seq != 4'hF && upd_mode == IMCC_UPD_PRESET_B |=> dac_cmd.source == 2'h2;
    endproperty
    a_preset: assert property (p_preset) else $error("wrong preset source");
endmodule // imcc_top

// ---- testbench/imcc_host_model.sv ----
module imcc_host_model (
    // Clock
    input wire logic sys_clk,
    // Avalon-MM master side
    output logic [4:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
    end

    // ====================================
    // One access, held until waitrequest is seen low
    // host ordering duties
    task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released lines stop showing the last value
        avs_address <= ~a;
        avs_writedata <= ~avs_writedata;
    endtask
endmodule // imcc_host_model

// ---- testbench/irq_mask_and_conversion_control_tb.sv ----
`include "imcc_defs.svh"

module irq_mask_and_conversion_control_tb import imcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int STEP = 16;
    localparam int CONV[4] = '{1250, 1000, 750, 625};
    localparam int PEND[13] = '{15, 12, 13, 14, 9, 10, 11, 6, 7, 8, 5, 2, 1};
    localparam logic [4:0] MSK = `IMCC_OFS_MASK;
    localparam logic [4:0] CTL = `IMCC_OFS_CTRL;
    localparam logic [4:0] PND = `IMCC_OFS_PEND;

    logic sys_clk;
    logic sys_rst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic avs_waitrequest;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [3:0] avs_byteenable;
    logic [11:0] adc_port_map;
    logic [11:0] dac_port_map;
    logic [11:0] gpi_pins;
    logic conversion_start_in;
    logic dac_new_data;
    logic [3:0] dac_new_port;
    imcc_events_t events;
    imcc_port_cmd_t adc_cmd;
    imcc_port_cmd_t dac_cmd;
    logic [1:0] conversion_rate_sel;
    logic int_n;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int adc_gap = 0;
    int adc_last = 0;
    int low_run = 0;
    int low_last = 0;
    logic [31:0] rd_q[$];
    logic [3:0] adc_q[$];
    logic [5:0] dac_q[$];

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    imcc_top #(.PORTS(12), .DAC_STEP_CYC(STEP)) i_dut (.sys_clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .adc_port_map, .dac_port_map, .gpi_pins, .conversion_start_in,
        .events, .dac_new_data, .dac_new_port, .adc_cmd, .dac_cmd, .conversion_rate_sel,
        .int_n);

    imcc_host_model i_host (.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest);

    // ====================================
    // Helpers
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic clks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        i_host.access(a, 1'b1, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        rd_q.push_back({16'h0000, e});
        i_host.access(a, 1'b0, 16'h0000);
    endtask

    task automatic start_pulse();
        conversion_start_in <= 1'b1;
        clks(4);
        conversion_start_in <= 1'b0;
        clks(1);
    endtask

    function automatic logic [3:0] nxt(input logic [3:0] p, input logic [11:0] m);
        logic [3:0] q;
        q = p;
        for (int k = 0; k < 12; k++) begin
            q = (q == 4'hB) ? 4'h0 : q + 4'h1;
            if (m[q]) return q;
        end
        return p;
    endfunction

    // ====================================
    // Output watcher
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc >= 30000) begin
            error_cnt++;
            summarize();
        end
        if (int_n === 1'b0) begin
            low_run <= low_run + 1;
        end else if (low_run != 0) begin
            low_last <= low_run;
            low_run <= 0;
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            cmp("readdata", rd_q.pop_front(), avs_readdata);
        end
        if (adc_cmd.strobe === 1'b1) begin
            adc_gap <= cyc - adc_last;
            adc_last <= cyc;
            if (adc_q.size() == 0) cmp("adc_strobe", 32'h0, 32'h1);
            else cmp("adc_port", 32'(adc_q.pop_front()), 32'(adc_cmd.port));
        end
        if (dac_cmd.strobe === 1'b1 && dac_q.size() > 0) begin
            cmp("dac_cmd", 32'(dac_q.pop_front()), 32'({dac_cmd.source, dac_cmd.port}));
        end
    end

    // ====================================
    // Main sequence
    initial begin
        logic [23:0] md;
        logic [11:0] st;
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] p;
        logic [1:0] r;
        logic [1:0] src;
        sys_rst = 1'b1;
        adc_port_map = 12'h000;
        dac_port_map = 12'h000;
        gpi_pins = 12'h000;
        conversion_start_in = 1'b0;
        dac_new_data = 1'b0;
        dac_new_port = 4'h0;
        events = '0;
        void'($urandom(32'h4d44));
        clks(10);
        sys_rst <= 1'b0;
        clks(2);
        rd(MSK, `IMCC_RST_MASK);
        rd(`IMCC_OFS_EDGE_LO, 16'h0000);
        rd(`IMCC_OFS_EDGE_HI, 16'h0000);
        rd(CTL, 16'h0000);
        wr(5'h1C, 16'h1234);
        rd(5'h1C, 16'h0000);
        wr(MSK, 16'hFFEF);
        rd(MSK, 16'hFFFF);
        // each event-port cause through its mask bit
        for (int i = 0; i < 13; i++) begin
            events <= imcc_events_t'(13'h1 << i);
            clks(1);
            events <= '0;
            clks(4);
            cmp("int_n", 32'h1, 32'(int_n));
            wr(MSK, ~(16'h1 << PEND[i]));
            clks(3);
            cmp("int_n", 32'h0, 32'(int_n));
            rd(PND, 16'h1 << PEND[i]);
            clks(3);
            cmp("int_n", 32'h1, 32'(int_n));
            wr(MSK, 16'hFFFF);
        end
        // edge modes, ports 0..3 get every code
        md = {12'($urandom()), 12'h0E4};
        wr(`IMCC_OFS_EDGE_LO, {md[11:0], 4'h0});
        wr(`IMCC_OFS_EDGE_HI, {md[21:12], 4'h0, md[23:22]});
        for (int ph = 0; ph < 2; ph++) begin
            for (int k = 0; k < 12; k++) st[k] = md[2 * k + ph];
            gpi_pins <= (ph == 0) ? 12'hFFF : 12'h000;
            clks(6);
            cmp("int_n", 32'h1, 32'(int_n));
            wr(MSK, 16'hFFE7);
            clks(3);
            cmp("int_n", 32'(st == 12'h000), 32'(int_n));
            rd(PND, {12'h000, |st, 3'h0});
            rd(`IMCC_OFS_STAT_LO, {st[10:6], 3'h0, st[5:0], 2'h0});
            rd(`IMCC_OFS_STAT_HI, {15'h0000, st[11]});
            rd(`IMCC_OFS_STAT_LO, 16'h0000);
            wr(MSK, 16'hFFFF);
        end
        // ADC sweep, idle, single and continuous modes at a random rate, then DAC update modes
        r = 2'($urandom());
        a = 4'($urandom_range(5));
        b = 4'(6 + $urandom_range(5));
        adc_port_map <= (12'h001 << a) | (12'h001 << b);
        wr(CTL, {10'h000, r, 4'h1});
        rd(CTL, {10'h000, r, 4'h1});
        cmp("rate_sel", 32'(r), 32'(conversion_rate_sel));
        adc_q.push_back(a);
        adc_q.push_back(b);
        start_pulse();
        while (adc_q.size() > 0) clks(1);
        clks(CONV[r] + 8);
        cmp("adc_gap", 32'(CONV[r]), 32'(adc_gap));
        cmp("int_n", 32'h1, 32'(int_n));
        wr(MSK, 16'hFFFE);
        clks(3);
        cmp("int_n", 32'h0, 32'(int_n));
        rd(PND, 16'h0001);
        wr(MSK, 16'hFFFF);
        wr(CTL, {10'h000, r, 4'h0});
        start_pulse();
        clks(1300);
        wr(CTL, {10'h000, r, 4'h2});
        for (int k = 0; k < 2; k++) begin
            adc_q.push_back((k == 0) ? a : b);
            start_pulse();
            while (adc_q.size() > 0) clks(1);
            clks(CONV[r] + 8);
        end
        wr(CTL, {10'h000, r, 4'h0});
        rd(PND, 16'h0000);
        adc_port_map <= 12'h001 << a;
        wr(CTL, {10'h000, r, 4'h3});
        repeat (3) adc_q.push_back(a);
        start_pulse();
        while (adc_q.size() > 0) clks(1);
        wr(CTL, {10'h000, r, 4'h0});
        cmp("low_pulse", 32'(100 / 4), 32'(low_last));
        rd(PND, 16'h0001);
        dac_port_map <= 12'($urandom()) | 12'h491;
        for (int m = 0; m < 4; m++) begin
            src = (m < 2) ? 2'h0 : 2'(m - 1);
            wr(CTL, {12'h000, 2'(m), 2'h0});
            do clks(1); while (dac_cmd.strobe !== 1'b1);
            p = dac_cmd.port;
            clks(1);
            if (m == 1) begin
                p = nxt(nxt(p, dac_port_map), dac_port_map);
                // single immediate request in the run
                dac_new_port <= p;
                dac_new_data <= 1'b1;
                clks(1);
                dac_new_data <= 1'b0;
                dac_q.push_back({src, p});
            end
            repeat (3) begin
                p = nxt(p, dac_port_map);
                dac_q.push_back({src, p});
            end
            while (dac_q.size() > 0) clks(1);
        end
        summarize();
    end
endmodule // irq_mask_and_conversion_control_tb
